// >>> logic/anlt_ctrl.v
// Notes on behaviour
// - while the master override enable is set, the one-hot lane pick chooses the negotiation master.
// - with partner takeover set, requests toward the partner equalizer come from software values.
// - with partner takeover clear, the training logic's own requests go to the partner.
// - partner takeover works with update bits 7 to 4 and the low byte of the four coefficient words.
// - with local takeover set, software sets the local transmit equalizer coefficients.
// - with local takeover clear, local coefficients follow the commands received from the partner.
// - local takeover works with update bits 11 to 8 and bits 23 to 16 of the coefficient words.
// - writing one to the lane 1 restart bit restarts that lane's training, writing zero does nothing.
// - the lane 1 restart bit clears itself and drives the restart-training variable.
// - while the master override enable is clear, the build-time master lane is used.
// - a partner update strobe written one under takeover sends the software values, then clears.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "anlt_map.vh"

module anlt_ctrl
#(
  parameter [3:0] BUILD_MASTER = `ANLT_DEF_MASTER
)
(
  input wire i_clk,
  input wire i_rst_b,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [9:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire [31:0] i_lt_lp_req,
  input wire [3:0] i_lt_lp_req_vld,
  input wire [31:0] i_rx_loc_coef,
  input wire [3:0] i_rx_loc_coef_vld,
  output wire [31:0] o_lp_req,
  output wire [3:0] o_lp_req_vld,
  output wire [31:0] o_loc_coef,
  output wire [3:0] o_loc_coef_vld,
  output reg [3:0] o_master_lane,
  output reg o_restart_training_l1,
  output wire o_partner_coefficient_takeover,
  output wire o_local_coefficient_takeover
);

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  wire req;
  wire wr;
  wire hit_an_ctrl;
  wire hit_pick;
  wire hit_ovr;
  wire hit_lane;
  wire hit_coef;
  reg [31:0] next_rdata;

  // request pending, write commits on the edge that sees ack high
  assign req = i_wb_cyc & i_wb_stb;
  assign wr = req & i_wb_we & o_wb_ack;

  // address compares on word index
  assign hit_an_ctrl = (i_wb_adr == `ANLT_IDX_AN_CTRL);
  assign hit_pick = (i_wb_adr == `ANLT_IDX_MASTER_PICK);
  assign hit_ovr = (i_wb_adr == `ANLT_IDX_COEF_OVR);
  assign hit_lane = (i_wb_adr == `ANLT_IDX_LANE_CTRL);
  assign hit_coef = (i_wb_adr >= `ANLT_IDX_COEF_BASE) && (i_wb_adr <= `ANLT_IDX_COEF_LAST);

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  reg negotiation_master_override_on;
  reg [3:0] negotiation_master_lane_pick;
  reg partner_coefficient_takeover;
  reg local_coefficient_takeover;
  reg restart_l1;
  wire [3:0] lane_sel;
  wire pick_valid;

  // software-written fields with byte-lane enables
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      negotiation_master_override_on <= 1'b0;
      negotiation_master_lane_pick <= `ANLT_RST_PICK;
      partner_coefficient_takeover <= 1'b0;
      local_coefficient_takeover <= 1'b0;
    end
    else if (wr)
    begin
      if (hit_an_ctrl && i_wb_sel[0])
        negotiation_master_override_on <= i_wb_dat[`ANLT_BIT_MASTER_OVR];
      if (hit_pick && i_wb_sel[0])
        negotiation_master_lane_pick <= i_wb_dat[3:0];
      if (hit_ovr && i_wb_sel[2])
      begin
        partner_coefficient_takeover <= i_wb_dat[`ANLT_BIT_LP_TAKEOVER];
        local_coefficient_takeover <= i_wb_dat[`ANLT_BIT_LOC_TAKEOVER];
      end
    end
  end

  // lane 1 restart: set by a written one, cleared on the next edge
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      restart_l1 <= 1'b0;
    else if (wr && hit_lane && i_wb_sel[0] && i_wb_dat[`ANLT_BIT_RESTART_L1])
      restart_l1 <= 1'b1;
    else
      restart_l1 <= 1'b0;
  end

  // restart-training variable follows the self-clearing bit
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_restart_training_l1 <= 1'b0;
    else
      o_restart_training_l1 <= restart_l1;
  end

  assign o_partner_coefficient_takeover = partner_coefficient_takeover;
  assign o_local_coefficient_takeover = local_coefficient_takeover;

  // ------------------------------------------------------------------
  // negotiation master lane
  // ------------------------------------------------------------------
  anlt_lane_sel #(
    .BUILD_MASTER(BUILD_MASTER)
  ) u_lane_sel (
    .i_override_on(negotiation_master_override_on),
    .i_pick(negotiation_master_lane_pick),
    .o_lane(lane_sel),
    .o_pick_valid(pick_valid)
  );

  // registered master lane toward the negotiation logic
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_master_lane <= BUILD_MASTER;
    else
      o_master_lane <= lane_sel;
  end

  // ------------------------------------------------------------------
  // per-lane coefficient storage, strobes and steering
  // ------------------------------------------------------------------
  wire [31:0] sw_lp_all;
  wire [31:0] sw_loc_all;
  wire [3:0] lp_upd_all;
  wire [3:0] loc_upd_all;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_lane
      wire hit_me;
      wire wr_me;
      wire wr_lane;
      reg [7:0] sw_lp;
      reg [7:0] sw_loc;
      reg lp_upd;
      reg loc_upd;
      reg [7:0] lp_out;
      reg lp_vld;
      reg [7:0] loc_out;
      reg loc_vld;

      assign hit_me = (i_wb_adr == (`ANLT_IDX_COEF_BASE + g));
      assign wr_me = wr & hit_me;
      assign wr_lane = wr & hit_lane;

      // software coefficient values for this lane
      always @(posedge i_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          sw_lp <= `ANLT_RST_COEF;
          sw_loc <= `ANLT_RST_COEF;
        end
        else if (wr_me)
        begin
          if (i_wb_sel[0])
            sw_lp <= i_wb_dat[`ANLT_LSB_LP_COEF +: 8];
          if (i_wb_sel[2])
            sw_loc <= i_wb_dat[`ANLT_LSB_LOC_COEF +: 8];
        end
      end

      // self-clearing update strobes
      always @(posedge i_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          lp_upd <= 1'b0;
          loc_upd <= 1'b0;
        end
        else
        begin
          lp_upd <= wr_lane & i_wb_sel[0] & i_wb_dat[`ANLT_LSB_LP_UPD + g];
          loc_upd <= wr_lane & i_wb_sel[1] & i_wb_dat[`ANLT_LSB_LOC_UPD + g];
        end
      end

      // partner requests: software under takeover, else training logic
      always @(posedge i_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          lp_out <= 8'h00;
          lp_vld <= 1'b0;
        end
        else if (partner_coefficient_takeover)
        begin
          lp_out <= sw_lp;
          lp_vld <= lp_upd;
        end
        else
        begin
          lp_out <= i_lt_lp_req[g*8 +: 8];
          lp_vld <= i_lt_lp_req_vld[g];
        end
      end

      // local coefficients: software under takeover, else partner commands
      always @(posedge i_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          loc_out <= 8'h00;
          loc_vld <= 1'b0;
        end
        else if (local_coefficient_takeover)
        begin
          loc_out <= sw_loc;
          loc_vld <= loc_upd;
        end
        else
        begin
          loc_out <= i_rx_loc_coef[g*8 +: 8];
          loc_vld <= i_rx_loc_coef_vld[g];
        end
      end

      assign sw_lp_all[g*8 +: 8] = sw_lp;
      assign sw_loc_all[g*8 +: 8] = sw_loc;
      assign lp_upd_all[g] = lp_upd;
      assign loc_upd_all[g] = loc_upd;
      assign o_lp_req[g*8 +: 8] = lp_out;
      assign o_lp_req_vld[g] = lp_vld;
      assign o_loc_coef[g*8 +: 8] = loc_out;
      assign o_loc_coef_vld[g] = loc_vld;
    end
  endgenerate

  // ------------------------------------------------------------------
  // read mux and acknowledge
  // ------------------------------------------------------------------
  // unmapped words read as zero; strobe bits read back while high
  always @*
  begin
    next_rdata = 32'h0000_0000;
    if (hit_an_ctrl)
    begin
      next_rdata[`ANLT_BIT_MASTER_OVR] = negotiation_master_override_on;
      next_rdata[3:0] = o_master_lane; // live master lane
      next_rdata[4] = pick_valid;
    end
    else if (hit_pick)
      next_rdata[3:0] = negotiation_master_lane_pick;
    else if (hit_ovr)
    begin
      next_rdata[`ANLT_BIT_LP_TAKEOVER] = partner_coefficient_takeover;
      next_rdata[`ANLT_BIT_LOC_TAKEOVER] = local_coefficient_takeover;
    end
    else if (hit_lane)
    begin
      next_rdata[`ANLT_BIT_RESTART_L1] = restart_l1;
      next_rdata[`ANLT_LSB_LP_UPD +: 4] = lp_upd_all;
      next_rdata[`ANLT_LSB_LOC_UPD +: 4] = loc_upd_all;
    end
    else if (hit_coef)
    begin
      next_rdata[`ANLT_LSB_LP_COEF +: 8] = sw_lp_all[i_wb_adr[1:0]*8 +: 8];
      next_rdata[`ANLT_LSB_LOC_COEF +: 8] = sw_loc_all[i_wb_adr[1:0]*8 +: 8];
    end
  end

  // one wait state: ack rises the cycle after the request, drops next
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= req & ~o_wb_ack;
      if (req && !o_wb_ack)
        o_wb_dat <= next_rdata;
    end
  end

endmodule // anlt_ctrl

// >>> include/anlt_map.vh
`ifndef ANLT_MAP_VH
`define ANLT_MAP_VH

// ----------------------------------------------------------------------
// register word indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define ANLT_IDX_AN_CTRL 10'h0c0
`define ANLT_IDX_MASTER_PICK 10'h0cc
`define ANLT_IDX_COEF_OVR 10'h0d0
`define ANLT_IDX_LANE_CTRL 10'h0d1
`define ANLT_IDX_COEF_BASE 10'h0d4
`define ANLT_IDX_COEF_LAST 10'h0d7

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ANLT_BIT_MASTER_OVR 6
`define ANLT_BIT_LP_TAKEOVER 16
`define ANLT_BIT_LOC_TAKEOVER 17
`define ANLT_BIT_RESTART_L1 1
`define ANLT_LSB_LP_UPD 4
`define ANLT_LSB_LOC_UPD 8
`define ANLT_LSB_LP_COEF 0
`define ANLT_LSB_LOC_COEF 16

// ----------------------------------------------------------------------
// reset values, build-time defaults and the lane-one constant
// ----------------------------------------------------------------------
`define ANLT_RST_PICK 4'h0
`define ANLT_RST_COEF 8'h00
`define ANLT_DEF_MASTER 4'h1
`define ANLT_LANE_ONE 4'h1

`endif

// >>> logic/anlt_lane_sel.v
`timescale 1ns/100ps
`include "anlt_map.vh"

// --------------------------------------------------------------------
// auto-negotiation master lane resolver
// --------------------------------------------------------------------
module anlt_lane_sel
#(
  parameter [3:0] BUILD_MASTER = `ANLT_DEF_MASTER
)
(
  input wire i_override_on,
  input wire [3:0] i_pick,
  output wire [3:0] o_lane,
  output wire o_pick_valid
);

  // exactly one bit set in the lane pick
  assign o_pick_valid = (i_pick != 4'h0) && ((i_pick & (i_pick - `ANLT_LANE_ONE)) == 4'h0);

  // software pick only when enabled and one-hot, else build-time lane
  assign o_lane = (i_override_on && o_pick_valid) ? i_pick : BUILD_MASTER;

endmodule // anlt_lane_sel

// >>> dv/anlt_ctrl_asserts.sv
`timescale 1ns/100ps
// ------------------------------
// port checks
// ------------------------------
module anlt_ctrl_asserts
#(
  parameter [3:0] BUILD_MASTER = 4'h1
)
(
  input wire i_clk,
  input wire i_rst_b,
  input wire [31:0] i_lt_lp_req,
  input wire [3:0] i_lt_lp_req_vld,
  input wire [31:0] i_rx_loc_coef,
  input wire [3:0] i_rx_loc_coef_vld,
  input wire o_wb_ack,
  input wire [31:0] o_lp_req,
  input wire [3:0] o_lp_req_vld,
  input wire [31:0] o_loc_coef,
  input wire [3:0] o_loc_coef_vld,
  input wire [3:0] o_master_lane,
  input wire o_restart_training_l1,
  input wire o_partner_coefficient_takeover,
  input wire o_local_coefficient_takeover
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // pass-through, strobe and pulse relations, one-hot master lane
  AST_LP_PASS: assert property ($past(i_rst_b) && !$past(o_partner_coefficient_takeover)
    && !o_partner_coefficient_takeover |-> o_lp_req == $past(i_lt_lp_req)
    && o_lp_req_vld == $past(i_lt_lp_req_vld)) else $error("partner path not passed");
  AST_LOC_PASS: assert property ($past(i_rst_b) && !$past(o_local_coefficient_takeover)
    && !o_local_coefficient_takeover |-> o_loc_coef == $past(i_rx_loc_coef)
    && o_loc_coef_vld == $past(i_rx_loc_coef_vld)) else $error("local path not passed");
  AST_LP_STROBE: assert property ($past(o_partner_coefficient_takeover)
    && o_partner_coefficient_takeover && o_lp_req_vld != 4'h0 |-> $past(o_wb_ack, 2))
    else $error("partner valid without write");
  AST_LOC_STROBE: assert property ($past(o_local_coefficient_takeover)
    && o_local_coefficient_takeover && o_loc_coef_vld != 4'h0 |-> $past(o_wb_ack, 2))
    else $error("local valid without write");
  AST_LP_VLD_ONE: assert property (o_partner_coefficient_takeover && o_lp_req_vld != 4'h0
    |=> !o_partner_coefficient_takeover || o_lp_req_vld == 4'h0)
    else $error("partner valid too long");
  AST_RESTART_ONE: assert property (o_restart_training_l1 |=> !o_restart_training_l1)
    else $error("restart pulse too long");
  AST_RESTART_CAUSE: assert property (o_restart_training_l1 |-> $past(o_wb_ack, 2))
    else $error("restart without write");
  AST_MASTER_ONEHOT: assert property ($onehot(o_master_lane))
    else $error("master lane not one-hot");
  // values seen at the first edge out of reset
  AST_MASTER_RST: assert property ($rose(i_rst_b) |-> o_master_lane == BUILD_MASTER)
    else $error("master lane not build-time after reset");
  AST_TAKEOVER_RST: assert property ($rose(i_rst_b) |-> !o_partner_coefficient_takeover
    && !o_local_coefficient_takeover && !o_restart_training_l1)
    else $error("takeover or restart set after reset");
endmodule // anlt_ctrl_asserts

bind anlt_ctrl anlt_ctrl_asserts #(.BUILD_MASTER(BUILD_MASTER)) anlt_ctrl_asserts_inst (
  .i_clk, .i_rst_b, .i_lt_lp_req, .i_lt_lp_req_vld, .i_rx_loc_coef, .i_rx_loc_coef_vld,
  .o_wb_ack, .o_lp_req, .o_lp_req_vld, .o_loc_coef, .o_loc_coef_vld, .o_master_lane,
  .o_restart_training_l1, .o_partner_coefficient_takeover, .o_local_coefficient_takeover);

// >>> dv/anlt_lt_model.sv
`timescale 1ns/100ps
// ------------------------------
// training logic stand-in
// ------------------------------
module anlt_lt_model
(
  input wire i_clk,
  output reg [31:0] o_lp_req = 32'h0,
  output reg [3:0] o_lp_req_vld = 4'h0,
  output reg [31:0] o_loc_coef = 32'h0,
  output reg [3:0] o_loc_coef_vld = 4'h0
);
  integer seed = 58787;
  // fresh requests every cycle so a stale path shows
  always @(posedge i_clk)
  begin
    o_lp_req <= $random(seed);
    o_lp_req_vld <= $random(seed);
    o_loc_coef <= $random(seed);
    o_loc_coef_vld <= $random(seed);
  end
endmodule // anlt_lt_model

// >>> dv/testbench.sv
`timescale 1ns/100ps
// ------------------------------
// register bank bench
// ------------------------------
module testbench;
  reg i_clk = 1'b0;
  reg i_rst_b = 1'b0;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg we = 1'b0;
  reg [9:0] adr = 10'h000;
  reg [3:0] sel = 4'hf;
  reg [31:0] dat = 32'h0;
  reg mon = 1'b0;
  reg [31:0] q;
  reg [31:0] c;
  reg [31:0] p_lp;
  reg [31:0] p_loc;
  reg [7:0] p_v;
  integer n_mismatch = 0;
  integer n_checks = 0;
  integer seed = 58787;
  integer g;
  integer k;
  wire [31:0] rd, lt_req, rx_coef, lp, loc;
  wire [3:0] lt_vld, rx_vld, lp_vld, loc_vld, mlane;
  wire ack, rst_l1, tk_lp, tk_loc;

  anlt_lt_model anlt_lt_model_inst (.i_clk(i_clk), .o_lp_req(lt_req), .o_lp_req_vld(lt_vld),
    .o_loc_coef(rx_coef), .o_loc_coef_vld(rx_vld));
  anlt_ctrl #(.BUILD_MASTER(4'h1)) anlt_ctrl_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(dat), .o_wb_dat(rd), .o_wb_ack(ack), .i_lt_lp_req(lt_req),
    .i_lt_lp_req_vld(lt_vld), .i_rx_loc_coef(rx_coef), .i_rx_loc_coef_vld(rx_vld),
    .o_lp_req(lp), .o_lp_req_vld(lp_vld), .o_loc_coef(loc), .o_loc_coef_vld(loc_vld),
    .o_master_lane(mlane), .o_restart_training_l1(rst_l1),
    .o_partner_coefficient_takeover(tk_lp), .o_local_coefficient_takeover(tk_loc));

  // clock
  initial forever #4 i_clk = ~i_clk;

  // shared mismatch report
  task report(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // register read data compare
  task chk_reg(input [31:0] got, input [31:0] exp);
    report(got, exp);
  endtask
  // output pin compare
  task chk_pin(input [31:0] got, input [31:0] exp);
    report(got, exp);
  endtask

  // one classic bus cycle, held until ack
  task wb(input w, input [9:0] a, input [31:0] d);
    integer t;
    begin
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      t = 0;
      @(posedge i_clk);
      while (ack !== 1'b1 && t < 20)
      begin
        @(posedge i_clk);
        t = t + 1;
      end
      if (t == 20)
        n_mismatch = n_mismatch + 1;
      q = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  // read and compare
  task rd_chk(input [9:0] a, input [31:0] exp);
    begin
      wb(1'b0, a, 32'h0);
      chk_reg(q, exp);
    end
  endtask
  // count restart pulses over a short span
  task pulses(output integer n);
    begin
      n = 0;
      repeat (6)
      begin
        @(posedge i_clk);
        if (rst_l1 === 1'b1)
          n = n + 1;
      end
    end
  endtask
  // verdict
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // pass-through model: output equals last cycle's training input
  always @(posedge i_clk)
  begin
    if (mon)
    begin
      chk_pin(lp, p_lp);
      chk_pin(loc, p_loc);
      chk_pin({24'h0, lp_vld, loc_vld}, {24'h0, p_v});
    end
    p_lp = lt_req;
    p_loc = rx_coef;
    p_v = {lt_vld, rx_vld};
  end

  // watchdog
  initial
  begin
    #40000;
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end

  // main sequence
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd_chk(10'h0cc, 32'h0);
    rd_chk(10'h0d0, 32'h0);
    rd_chk(10'h0d1, 32'h0);
    rd_chk(10'h3ff, 32'h0);
    chk_pin({28'h0, mlane}, 32'h1);
    wb(1'b1, 10'h0c0, 32'h40);
    for (k = 0; k < 6; k = k + 1)
    begin
      c = (k < 4) ? (32'h1 << k) : (k == 4 ? 32'h3 : ($random(seed) & 32'hf));
      wb(1'b1, 10'h0cc, c);
      repeat (2) @(posedge i_clk);
      chk_pin({28'h0, mlane}, ($countones(c) == 1) ? c : 32'h1);
      rd_chk(10'h0cc, c);
    end
    wb(1'b1, 10'h0cc, 32'h4);
    wb(1'b1, 10'h0c0, 32'h0);
    repeat (2) @(posedge i_clk);
    chk_pin({28'h0, mlane}, 32'h1);
    mon = 1'b1;
    wb(1'b1, 10'h0d1, 32'hff0);
    repeat (4) @(posedge i_clk);
    mon = 1'b0;
    wb(1'b1, 10'h0d0, 32'h30000);
    rd_chk(10'h0d0, 32'h30000);
    chk_pin({30'h0, tk_loc, tk_lp}, 32'h3);
    for (g = 0; g < 4; g = g + 1)
    begin
      c = $random(seed) & 32'h00ff00ff;
      wb(1'b1, 10'h0d4 + g[9:0], c);
      rd_chk(10'h0d4 + g[9:0], c);
      wb(1'b1, 10'h0d1, 32'h110 << g);
      k = 0;
      while (lp_vld === 4'h0 && k < 4)
      begin
        @(posedge i_clk);
        k = k + 1;
      end
      chk_pin({28'h0, lp_vld}, 32'h1 << g);
      chk_pin({24'h0, lp[g*8 +: 8]}, {24'h0, c[7:0]});
      chk_pin({28'h0, loc_vld}, 32'h1 << g);
      chk_pin({24'h0, loc[g*8 +: 8]}, {24'h0, c[23:16]});
    end
    wb(1'b1, 10'h0d1, 32'h0);
    pulses(k);
    chk_pin(k, 32'h0);
    wb(1'b1, 10'h0d1, 32'h2);
    pulses(k);
    chk_pin(k, 32'h1);
    rd_chk(10'h0d1, 32'h0);
    tally_and_finish;
  end
endmodule // testbench
